/* File: pkg/ccpc_defines.svh */
// Register map, field positions, reset values and pipeline timing of the pixel correction core.
// Included by the core and the bench; holds definitions only.
`ifndef CCPC_DEFINES_SVH
`define CCPC_DEFINES_SVH
// Register select codes
`define CCPC_REG_CFG 3'h0
`define CCPC_REG_CFG2 3'h1
`define CCPC_REG_GAIN 3'h2
`define CCPC_REG_ODD 3'h3
`define CCPC_REG_EVEN 3'h4
`define CCPC_REG_AOFF 3'h5
`define CCPC_REG_TWOCH 3'h7
// Configuration fields
`define CCPC_CFG_SCALE 2:0
`define CCPC_CFG_DIST 5:3
`define CCPC_CFG_PTR 7:6
`define CCPC_CFG2_CDS 0
`define CCPC_CFG2_MONO 1
`define CCPC_TWOCH_EN 0
`define CCPC_GAIN_FIELD 3:0
`define CCPC_PTR_RSVD 2'h3
`define CCPC_RST_BYTE 8'h00
// Pipeline timing in conversion clocks
`define CCPC_ADC_LAT 2
`define CCPC_OFF_DLY 6
`define CCPC_GAIN_DLY 7
`define CCPC_PIX_LAT 6
`define CCPC_WORD_LAT 9
`endif

/* File: pkg/ccpc_pkg.sv */
// Types and shared decoders of the pixel correction core.
// Assumes nothing beyond the defines header.
package ccpc_pkg;
    // Multiplexer sequence, Gray coded along red, green, blue
    typedef enum logic [1:0] {SEQ_RED = 2'h0, SEQ_GREEN = 2'h1, SEQ_BLUE = 2'h3} ccpc_seq_e;
    typedef enum logic [2:0] {
        MODE_RGB_CDS = 3'h0, MODE_RGB_SHA = 3'h1, MODE_MONO_CDS = 3'h3,
        MODE_MONO_SHA = 3'h2, MODE_TWO_CH = 3'h6
    } ccpc_mode_e;

    // Color pointer code of a sequence state
    function automatic logic [1:0] ccpc_seq_ptr(input ccpc_seq_e s);
        case (s)
            SEQ_GREEN: ccpc_seq_ptr = 2'h1;
            SEQ_BLUE: ccpc_seq_ptr = 2'h2;
            default: ccpc_seq_ptr = 2'h0;
        endcase
    endfunction : ccpc_seq_ptr

    function automatic ccpc_seq_e ccpc_ptr_seq(input logic [1:0] p);
        case (p)
            2'h1: ccpc_ptr_seq = SEQ_GREEN;
            2'h2: ccpc_ptr_seq = SEQ_BLUE;
            default: ccpc_ptr_seq = SEQ_RED;
        endcase
    endfunction : ccpc_ptr_seq

    // Offset word width from pin distribution: 0 off, 1 8 bit, 2 9 bit, 3 10 bit
    function automatic logic [1:0] ccpc_off_w(input logic [2:0] d);
        if (d[0]) ccpc_off_w = 2'h3;
        else if (d[1]) ccpc_off_w = 2'h2;
        else if (d[2]) ccpc_off_w = 2'h1;
        else ccpc_off_w = 2'h0;
    endfunction : ccpc_off_w
endpackage : ccpc_pkg

/* File: rtl/ccpc_pix_buffer.sv */
// Two-entry pixel buffer with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ccpc_pix_buffer #(
    parameter int W = 12,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("buffer depth must be a power of two of at least 2");
    end

    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_r[rd_ptr_r];
    assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
            if (pop) rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
            cnt_r <= cnt_nxt;
            in_ready <= (cnt_nxt < CW'(DEPTH));
            out_valid <= (cnt_nxt != '0);
        end
    end

    no_overflow_a: assert property (@(posedge clk) disable iff (reset)
        cnt_r <= CW'(DEPTH)) else $error("buffer count above depth");
    full_stall_a: assert property (@(posedge clk) disable iff (reset)
        cnt_r == CW'(DEPTH) |-> !in_ready) else $error("ready while full");
endmodule : ccpc_pix_buffer

/* File: rtl/ccpc_core.sv */
// Register file, color sequencer and pixel correction pipeline of the imaging front end.
// Assumes core_clk is the conversion clock; pixel words and line start are synchronous to it.
`timescale 1ns/1ps
`include "ccpc_defines.svh"
module ccpc_core import ccpc_pkg::*; #(
    parameter int DATA_W = 12
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [DATA_W-1:0] adc_result,
    input wire logic [11:0] gain_pins,
    input wire logic [7:0] offset_pins,
    input wire logic line_start,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [2:0] register_select,
    input wire logic [7:0] host_register_bus,
    input wire logic pix_ready,
    output logic [DATA_W-1:0] bus_out_r,
    output logic [DATA_W-1:0] bus_oe_r,
    output logic pix_valid_r,
    output logic conv_ready,
    output ccpc_seq_e seq_r,
    output logic parity_r,
    output logic double_sampler_en_r,
    output logic [7:0] analog_offset_r,
    output logic [3:0] analog_gain_r
);
    if (DATA_W != 12) begin : g_bad_width
        $error("datapath serves 12-bit conversions only");
    end
    localparam logic [DATA_W-1:0] MAX_CODE = '1;

    //****************************************
    // Host port synchronisers
    //****************************************
    logic [13:0] host_s1_r;
    logic [13:0] host_s2_r;
    logic host_act;
    logic rd_act;
    logic wr_act;
    logic wr_act_d_r;
    logic wr_done;
    logic [7:0] wdat_r;
    logic [2:0] wsel_r;
    logic [2:0] hsel;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            host_s1_r <= 14'h3800;
            host_s2_r <= 14'h3800;
        end else begin
            host_s1_r <= {chip_select_n, write_strobe_n, read_strobe_n,
                          register_select, host_register_bus};
            host_s2_r <= host_s1_r;
        end
    end

    assign hsel = host_s2_r[10:8];
    assign rd_act = !host_s2_r[13] && !host_s2_r[11];
    assign wr_act = !host_s2_r[13] && !host_s2_r[12];
    assign host_act = rd_act || wr_act;
    assign wr_done = wr_act_d_r && !wr_act;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_act_d_r <= 1'b0;
            wdat_r <= `CCPC_RST_BYTE;
            wsel_r <= '0;
        end else begin
            wr_act_d_r <= wr_act;
            if (wr_act) begin
                wdat_r <= host_s2_r[7:0];
                wsel_r <= hsel;
            end
        end
    end

    //****************************************
    // Registers
    //****************************************
    logic [7:0] cfg_r;
    logic [7:0] cfg2_r;
    logic twoch_r;
    logic [7:0] aoff_r [4];
    logic [3:0] again_r [4];
    logic [7:0] odd_r [4];
    logic [7:0] even_r [4];
    logic [1:0] ptr;
    logic [7:0] rd_byte;

    assign ptr = cfg_r[`CCPC_CFG_PTR];

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cfg_r <= `CCPC_RST_BYTE;
            cfg2_r <= `CCPC_RST_BYTE;
            twoch_r <= 1'b0;
        end else if (wr_done) begin
            case (wsel_r)
                `CCPC_REG_CFG: cfg_r <= wdat_r;
                `CCPC_REG_CFG2: cfg2_r <= wdat_r;
                `CCPC_REG_TWOCH: twoch_r <= wdat_r[`CCPC_TWOCH_EN];
                default: ;
            endcase
        end
    end

    for (genvar c = 0; c < 4; c++) begin : g_color
        always_ff @(posedge core_clk) begin
            if (reset) begin
                aoff_r[c] <= `CCPC_RST_BYTE;
                again_r[c] <= '0;
                odd_r[c] <= `CCPC_RST_BYTE;
                even_r[c] <= `CCPC_RST_BYTE;
            end else if (wr_done && ptr == 2'(c) && ptr != `CCPC_PTR_RSVD) begin
                case (wsel_r)
                    `CCPC_REG_AOFF: aoff_r[c] <= wdat_r;
                    `CCPC_REG_GAIN: again_r[c] <= wdat_r[`CCPC_GAIN_FIELD];
                    `CCPC_REG_ODD: odd_r[c] <= wdat_r;
                    `CCPC_REG_EVEN: even_r[c] <= wdat_r;
                    default: ;
                endcase
            end
        end
    end

    always_comb begin
        case (hsel)
            `CCPC_REG_CFG: rd_byte = cfg_r;
            `CCPC_REG_CFG2: rd_byte = cfg2_r;
            `CCPC_REG_GAIN: rd_byte = {4'h0, again_r[ptr]};
            `CCPC_REG_ODD: rd_byte = odd_r[ptr];
            `CCPC_REG_EVEN: rd_byte = even_r[ptr];
            `CCPC_REG_AOFF: rd_byte = aoff_r[ptr];
            `CCPC_REG_TWOCH: rd_byte = {7'h00, twoch_r};
            default: rd_byte = 8'h00;
        endcase
    end

    //****************************************
    // Mode and color sequencer
    //****************************************
    ccpc_mode_e mode;
    logic adv;

    always_comb begin
        if (twoch_r) mode = MODE_TWO_CH;
        else if (cfg2_r[`CCPC_CFG2_MONO])
            mode = cfg2_r[`CCPC_CFG2_CDS] ? MODE_MONO_CDS : MODE_MONO_SHA;
        else mode = cfg2_r[`CCPC_CFG2_CDS] ? MODE_RGB_CDS : MODE_RGB_SHA;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            seq_r <= SEQ_RED;
            parity_r <= 1'b0;
        end else if (!line_start) begin
            seq_r <= SEQ_RED;
            parity_r <= 1'b0;
        end else if (adv) begin
            case (mode)
                MODE_MONO_CDS, MODE_MONO_SHA: begin
                    seq_r <= ccpc_ptr_seq(ptr);
                    parity_r <= !parity_r;
                end
                MODE_TWO_CH: begin
                    seq_r <= (seq_r == SEQ_GREEN) ? SEQ_BLUE : SEQ_GREEN;
                    if (seq_r == SEQ_BLUE) parity_r <= !parity_r;
                end
                default: begin
                    case (seq_r)
                        SEQ_RED: seq_r <= SEQ_GREEN;
                        SEQ_GREEN: seq_r <= SEQ_BLUE;
                        default: begin
                            seq_r <= SEQ_RED;
                            parity_r <= !parity_r;
                        end
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            double_sampler_en_r <= 1'b0;
            analog_offset_r <= `CCPC_RST_BYTE;
            analog_gain_r <= '0;
        end else begin
            double_sampler_en_r <= cfg2_r[`CCPC_CFG2_CDS];
            analog_offset_r <= aoff_r[ccpc_seq_ptr(seq_r)];
            analog_gain_r <= again_r[ccpc_seq_ptr(seq_r)];
        end
    end

    //****************************************
    // Pixel word capture and alignment
    //****************************************
    logic [1:0] off_w;
    logic [10:0] off_amt;
    logic [11:0] g12;
    logic [10:0] off_d [`CCPC_OFF_DLY+1];
    logic [11:0] gain_d [`CCPC_GAIN_DLY+1];
    logic [3:0] tag_d [`CCPC_ADC_LAT+1];

    assign off_w = ccpc_off_w(cfg_r[`CCPC_CFG_DIST]);

    always_comb begin
        case (off_w)
            2'h3: begin
                off_amt = {1'b0, gain_pins[1:0], offset_pins};
                g12 = {gain_pins[11:2], 2'h0};
            end
            2'h2: begin
                off_amt = {2'h0, gain_pins[0], offset_pins};
                g12 = {gain_pins[11:1], 1'h0};
            end
            2'h1: begin
                off_amt = {3'h0, offset_pins};
                g12 = gain_pins;
            end
            default: begin
                off_amt = '0;
                g12 = gain_pins;
            end
        endcase
        if (off_w == 2'h3 && &off_amt[9:0]) off_amt = 11'h400;
        else if (off_w == 2'h2 && &off_amt[8:0]) off_amt = 11'h200;
        else if (off_w == 2'h1 && &off_amt[7:0]) off_amt = 11'h100;
    end

    assign off_d[0] = off_amt;
    assign gain_d[0] = g12;
    assign tag_d[0] = {1'b1, parity_r, ccpc_seq_ptr(seq_r)};

    for (genvar i = 0; i < `CCPC_GAIN_DLY; i++) begin : g_gain_dly
        always_ff @(posedge core_clk) begin
            if (adv) gain_d[i+1] <= gain_d[i];
        end
    end
    for (genvar i = 0; i < `CCPC_OFF_DLY; i++) begin : g_off_dly
        always_ff @(posedge core_clk) begin
            if (adv) off_d[i+1] <= off_d[i];
        end
    end
    for (genvar i = 0; i < `CCPC_ADC_LAT; i++) begin : g_tag_dly
        always_ff @(posedge core_clk) begin
            if (reset) tag_d[i+1] <= '0;
            else if (adv) tag_d[i+1] <= tag_d[i];
        end
    end

    //****************************************
    // Correction pipeline
    //****************************************
    logic [3:0] tag;
    logic signed [8:0] oe_off;
    logic signed [13:0] oe_sum;
    logic [DATA_W-1:0] oe_r;
    logic oe_vld_r;
    logic [DATA_W-1:0] sub_r;
    logic sub_vld_r;
    logic signed [13:0] sub_dif;
    logic [23:0] prod;
    logic [14:0] mul_sum;
    logic [DATA_W-1:0] mul_out;
    logic [DATA_W-1:0] head;
    logic head_vld;
    logic pop;

    assign tag = tag_d[`CCPC_ADC_LAT];
    assign oe_off = (tag[2] && !twoch_r) ? 9'(signed'(odd_r[tag[1:0]]))
                                         : 9'(signed'(even_r[tag[1:0]]));
    assign oe_sum = 14'(signed'({1'b0, adc_result})) + 14'(oe_off);
    assign sub_dif = 14'(signed'({1'b0, oe_r})) - 14'(signed'({1'b0, off_d[`CCPC_OFF_DLY]}));
    assign prod = sub_r * gain_d[`CCPC_GAIN_DLY];

    always_comb begin
        case (cfg_r[`CCPC_CFG_SCALE])
            3'h1: mul_sum = 15'(sub_r) + 15'(prod >> 12);
            3'h2, 3'h3: mul_sum = 15'(sub_r) + 15'(prod >> 11);
            default: mul_sum = 15'(sub_r) + 15'(prod >> 10);
        endcase
        if (cfg_r[`CCPC_CFG_SCALE] == 3'h0) mul_out = sub_r;
        else if (mul_sum > 15'(MAX_CODE)) mul_out = MAX_CODE;
        else mul_out = mul_sum[DATA_W-1:0];
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            oe_r <= '0;
            oe_vld_r <= 1'b0;
            sub_r <= '0;
            sub_vld_r <= 1'b0;
        end else if (adv) begin
            oe_vld_r <= tag[3];
            if (oe_sum < 0) oe_r <= '0;
            else if (oe_sum > 14'(MAX_CODE)) oe_r <= MAX_CODE;
            else oe_r <= oe_sum[DATA_W-1:0];
            sub_vld_r <= oe_vld_r;
            if (off_w == 2'h0) sub_r <= oe_r;
            else if (sub_dif < 0) sub_r <= '0;
            else sub_r <= sub_dif[DATA_W-1:0];
        end
    end

    ccpc_pix_buffer #(.W(DATA_W), .DEPTH(2)) u_buf (
        .clk(core_clk),
        .reset(reset),
        .in_valid(sub_vld_r),
        .in_ready(adv),
        .in_data(mul_out),
        .out_valid(head_vld),
        .out_ready(pix_ready && !host_act),
        .out_data(head)
    );
    assign conv_ready = adv;
    assign pop = head_vld && pix_ready && !host_act;

    //****************************************
    // Shared output bus
    //****************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            bus_out_r <= '0;
            bus_oe_r <= '0;
            pix_valid_r <= 1'b0;
        end else begin
            pix_valid_r <= pop;
            if (rd_act) begin
                bus_out_r <= {{(DATA_W-8){1'b0}}, rd_byte};
                bus_oe_r <= {{(DATA_W-8){1'b0}}, 8'hff};
            end else if (wr_act) begin
                bus_oe_r <= '0;
            end else begin
                bus_oe_r <= '1;
                if (pop) bus_out_r <= head;
            end
        end
    end

    line_reset_a: assert property (@(posedge core_clk) disable iff (reset)
        !line_start |=> seq_r == SEQ_RED && !parity_r) else $error("line start reset missed");
    rgb_order_a: assert property (@(posedge core_clk) disable iff (reset)
        line_start && adv && (mode == MODE_RGB_CDS || mode == MODE_RGB_SHA) &&
        seq_r == SEQ_RED |=> seq_r == SEQ_GREEN)
        else $error("red not followed by green");
    parity_flip_a: assert property (@(posedge core_clk) disable iff (reset)
        line_start && adv && mode == MODE_RGB_SHA && seq_r == SEQ_BLUE
        |=> parity_r != $past(parity_r)) else $error("parity did not alternate");
    ptr_write_a: assert property (@(posedge core_clk) disable iff (reset)
        wr_done && wsel_r == `CCPC_REG_ODD && ptr != `CCPC_PTR_RSVD
        |=> odd_r[$past(ptr)] == $past(wdat_r)) else $error("offset copy not written");
    gain_rsvd_a: assert property (@(posedge core_clk) disable iff (reset)
        rd_act && hsel == `CCPC_REG_GAIN |=> bus_out_r[7:4] == 4'h0)
        else $error("reserved gain bits read nonzero");
    read_drive_a: assert property (@(posedge core_clk) disable iff (reset)
        rd_act |=> bus_oe_r == 12'h0ff && !pix_valid_r) else $error("read drive wrong");
    write_float_a: assert property (@(posedge core_clk) disable iff (reset)
        wr_act |=> bus_oe_r == 12'h000) else $error("bus driven during write");
    mul_bypass_a: assert property (@(posedge core_clk) disable iff (reset)
        cfg_r[`CCPC_CFG_SCALE] == 3'h0 |-> mul_out == sub_r) else $error("multiplier not bypassed");
    sub_bypass_a: assert property (@(posedge core_clk) disable iff (reset)
        adv && off_w == 2'h0 |=> sub_r == $past(oe_r)) else $error("subtracter not bypassed");
endmodule : ccpc_core

/* File: verif/ccpc_rx_model.sv */
// Pixel receiver model: takes corrected words off the shared bus, may stall.
// Assumes the core's clock and a valid pulse one rising edge after the valid/ready transfer, taken whatever ready is then.
`timescale 1ns/1ps
module ccpc_rx_model (
    input wire logic core_clk,
    input wire logic stall,
    input wire logic pix_valid_r,
    input wire logic [11:0] bus_out_r,
    output logic pix_ready
);
    logic [11:0] q[$];

    assign pix_ready = !stall;

    // Each valid pulse carries one word already handed over at the pop
    always @(posedge core_clk) begin
        if (pix_valid_r) begin
            q.push_back(bus_out_r);
        end
    end
endmodule : ccpc_rx_model

/* File: verif/ccpc_core_tb.sv */
// Self-checking bench of the pixel correction core.
// Assumes the receiver model and the core's defines header.
`timescale 1ns/1ps
`include "ccpc_defines.svh"
module ccpc_core_tb import ccpc_pkg::*;;
    typedef struct packed {logic wr; logic [2:0] sel; logic [7:0] d;} ccpc_acc_s;
    typedef struct packed {
        logic [7:0] cfg; logic [11:0] adc; logic [7:0] off; logic [11:0] gain; logic [11:0] exp;
    } ccpc_pix_s;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic line_start = 1'b0;
    logic chip_select_n = 1'b1;
    logic write_strobe_n = 1'b1;
    logic read_strobe_n = 1'b1;
    logic stall = 1'b0;
    logic [2:0] register_select = 3'h0;
    logic [7:0] host_register_bus = 8'h00;
    logic [7:0] offset_pins = 8'h00;
    logic [11:0] adc_result = 12'h100;
    logic [11:0] gain_pins = 12'h000;
    logic [11:0] bus_out_r, bus_oe_r;
    logic pix_valid_r, conv_ready, parity_r, pix_ready;
    logic double_sampler_en_r;
    logic [7:0] analog_offset_r;
    logic [3:0] analog_gain_r;
    logic [1:0] s0;
    ccpc_seq_e seq_r;
    int failures = 0;
    int n_checks = 0;
    int i, k;
    ccpc_acc_s acc [16] = '{
        '{1'b1, `CCPC_REG_CFG, 8'h00}, '{1'b1, `CCPC_REG_ODD, 8'hfd},
        '{1'b1, `CCPC_REG_EVEN, 8'h05}, '{1'b1, `CCPC_REG_AOFF, 8'hff},
        '{1'b1, `CCPC_REG_GAIN, 8'hf7}, '{1'b0, `CCPC_REG_GAIN, 8'h07},
        '{1'b0, `CCPC_REG_ODD, 8'hfd}, '{1'b1, `CCPC_REG_CFG, 8'h40},
        '{1'b1, `CCPC_REG_AOFF, 8'h12}, '{1'b0, `CCPC_REG_AOFF, 8'h12},
        '{1'b1, `CCPC_REG_CFG, 8'hc0}, '{1'b1, `CCPC_REG_AOFF, 8'h33},
        '{1'b1, `CCPC_REG_CFG, 8'h00}, '{1'b0, `CCPC_REG_AOFF, 8'hff},
        '{1'b1, 3'h6, 8'h55}, '{1'b0, 3'h6, 8'h00}};
    ccpc_pix_s pix [11] = '{
        '{8'h00, 12'h100, 8'h00, 12'h000, 12'h105},
        '{8'h00, 12'h100, 8'h10, 12'h800, 12'h105},
        '{8'h20, 12'h100, 8'h10, 12'h000, 12'h0f5},
        '{8'h20, 12'h100, 8'hff, 12'h000, 12'h005},
        '{8'h20, 12'h0f0, 8'hff, 12'h000, 12'h000},
        '{8'h08, 12'h100, 8'h00, 12'h001, 12'h005},
        '{8'h10, 12'h100, 8'h00, 12'h001, 12'h005},
        '{8'h21, 12'h100, 8'h00, 12'h000, 12'h105},
        '{8'h21, 12'h100, 8'h00, 12'h800, 12'h187},
        '{8'h21, 12'hfff, 8'h00, 12'hfff, 12'hfff},
        '{8'h22, 12'h100, 8'h00, 12'h800, 12'h20a}};
    logic [11:0] pat [9] = '{12'h100, 12'h100, 12'h0fd, 12'h100, 12'h100, 12'h105,
        12'h100, 12'h100, 12'h0fd};

    ccpc_core u_dut (.core_clk(core_clk), .reset(reset), .adc_result(adc_result),
        .gain_pins(gain_pins), .offset_pins(offset_pins), .line_start(line_start),
        .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n), .register_select(register_select),
        .host_register_bus(host_register_bus), .pix_ready(pix_ready), .bus_out_r(bus_out_r),
        .bus_oe_r(bus_oe_r), .pix_valid_r(pix_valid_r), .conv_ready(conv_ready),
        .seq_r(seq_r), .parity_r(parity_r), .double_sampler_en_r(double_sampler_en_r),
        .analog_offset_r(analog_offset_r), .analog_gain_r(analog_gain_r));
    ccpc_rx_model u_rx (.core_clk(core_clk), .stall(stall), .pix_valid_r(pix_valid_r),
        .bus_out_r(bus_out_r), .pix_ready(pix_ready));

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic host(input logic wr, input logic [2:0] sel, input logic [7:0] d);
        @(posedge core_clk);
        chip_select_n <= 1'b0;
        register_select <= sel;
        host_register_bus <= d;
        write_strobe_n <= !wr;
        read_strobe_n <= wr;
        repeat (5) @(posedge core_clk);
        #1;
        if (!wr) chk("read data", bus_out_r, {4'h0, d});
        chk("bus enable", bus_oe_r, wr ? 12'h000 : 12'h0ff);
        @(posedge core_clk);
        chip_select_n <= 1'b1;
        write_strobe_n <= 1'b1;
        read_strobe_n <= 1'b1;
        repeat (5) @(posedge core_clk);
    endtask : host

    task automatic settle(input int n);
        int s;
        s = u_rx.q.size();
        for (int j = 0; j < 400 && u_rx.q.size() < s + n; j++) @(posedge core_clk);
    endtask : settle

    task automatic summarize;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        summarize();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        repeat (12) @(posedge core_clk);
        #1;
        chk("idle enable", bus_oe_r, 12'hfff);
        @(posedge core_clk);
        adc_result <= 12'h120;
        k = 0;
        while (k < 12 && bus_out_r !== 12'h120) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        chk("latency", 12'(k), 12'h004);
        foreach (acc[n]) host(acc[n].wr, acc[n].sel, acc[n].d);
        foreach (pix[n]) begin
            host(1'b1, `CCPC_REG_CFG, pix[n].cfg);
            adc_result <= pix[n].adc;
            offset_pins <= pix[n].off;
            gain_pins <= pix[n].gain;
            settle(12);
            chk("pixel", u_rx.q[$], pix[n].exp);
        end
        host(1'b1, `CCPC_REG_CFG, 8'h20);
        adc_result <= 12'h100;
        offset_pins <= 8'h00;
        gain_pins <= 12'h000;
        settle(12);
        k = u_rx.q.size();
        offset_pins <= 8'h10;
        repeat (5) @(posedge core_clk);
        adc_result <= 12'h110;
        settle(12);
        for (i = k; i < u_rx.q.size(); i++) chk("aligned", u_rx.q[i], 12'h105);
        host(1'b1, `CCPC_REG_CFG, 8'h00);
        host(1'b1, `CCPC_REG_CFG2, 8'h01);
        offset_pins <= 8'h00;
        adc_result <= 12'h100;
        settle(8);
        #1;
        chk("line reset color", {10'h0, seq_r}, 12'h000);
        chk("line reset parity", {11'h0, parity_r}, 12'h000);
        chk("double sampler", {11'h0, double_sampler_en_r}, 12'h001);
        chk("analog offset", {4'h0, analog_offset_r}, 12'h0ff);
        chk("analog gain", {8'h0, analog_gain_r}, 12'h007);
        u_rx.q.delete();
        @(posedge core_clk);
        line_start <= 1'b1;
        repeat (4) @(posedge core_clk);
        stall <= 1'b1;
        repeat (12) @(posedge core_clk);
        #1;
        chk("stalled", {11'h0, conv_ready}, 12'h000);
        @(posedge core_clk);
        stall <= 1'b0;
        settle(30);
        i = 0;
        while (i < 30 && u_rx.q[i] !== 12'h100) i++;
        foreach (pat[j]) chk("color set", u_rx.q[i + j], pat[j]);
        host(1'b1, `CCPC_REG_CFG, 8'h80);
        host(1'b1, `CCPC_REG_CFG2, 8'h03);
        #1;
        chk("mono color", {10'h0, seq_r}, 12'h003);
        host(1'b1, `CCPC_REG_CFG2, 8'h02);
        #1;
        chk("mono hold color", {10'h0, seq_r}, 12'h003);
        chk("hold sampler", {11'h0, double_sampler_en_r}, 12'h000);
        host(1'b1, `CCPC_REG_TWOCH, 8'h01);
        #1;
        s0 = seq_r;
        @(posedge core_clk);
        #1;
        chk("two channel", {10'h0, seq_r ^ s0}, 12'h002);
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        chk("reset enable", bus_oe_r, 12'h000);
        chk("reset color", {10'h0, seq_r}, 12'h000);
        @(posedge core_clk);
        reset <= 1'b0;
        host(1'b0, `CCPC_REG_AOFF, 8'h00);
        summarize();
    end
endmodule : ccpc_core_tb
